// ### port34_pins.sv
`timescale 1ns/1ps
module port34_pins (
   // Clock and reset
   input  wire logic                mclk,
   input  wire logic                srst,
   // Special-function register bus
   input  wire port34_pkg::sfr_req_t sfr_req,
   output logic [7:0]               sfr_rdata,
   // Crossbar
   input  wire port34_pkg::xbar_t    p3_xbar,
   input  wire port34_pkg::xbar_t    p4_xbar,
   output logic [7:0]               p3_skip,
   // Port 3 pads
   input  wire logic [7:0]          p3_pin_in,
   output port34_pkg::pad_t          p3_pad,
   // Port 4 pads (bit 7 unused)
   input  wire logic [7:0]          p4_pin_in,
   output port34_pkg::pad_t          p4_pad
);
   import port34_pkg::*;

   logic [7:0] p3_analog_sel_q;
   logic [7:0] p3_output_mode_q;
   logic [7:0] p3_skip_q;
   logic [7:0] p3_data_q;
   logic [7:0] p4_data_q;
   logic [7:0] p4_output_mode_q;
   logic [7:0] p3_meta_q;
   logic [7:0] p3_sync_q;
   logic [7:0] p4_meta_q;
   logic [7:0] p4_sync_q;
   logic [7:0] rdata_q;
   logic [7:0] p3_val;
   logic [7:0] p4_val;
   logic [7:0] p3_pp_eff;

   // Active-low enable: a pin is driven when enabled and either push-pull
   // or driving a low; open-drain high releases the pad.
   function automatic logic [7:0] drive_n(input logic [7:0] val,
                                          input logic [7:0] pp,
                                          input logic [7:0] en);
      drive_n = ~(en & (pp | ~val));
   endfunction : drive_n

   function automatic logic wr_hit(input sfr_req_t req,
                                   input logic [7:0] addr);
      wr_hit = req.wr && (req.addr == addr);
   endfunction : wr_hit

   ////////////////////////////////////////////////////////////////////////
   // Configuration registers.
   ////////////////////////////////////////////////////////////////////////

   // Port-3 mode registers; writes land on the next edge.
   // mode registers
   always_ff @(posedge mclk) begin
      if (srst) begin
         p3_analog_sel_q  <= RST_P3_ANALOG_SEL;
         p3_output_mode_q <= RST_P3_OUTPUT_MODE;
         p3_skip_q        <= RST_P3_SKIP;
      end else begin
         if (wr_hit(sfr_req, ADDR_P3_ANALOG_SEL)) begin
            p3_analog_sel_q <= sfr_req.wdata;
         end
         if (wr_hit(sfr_req, ADDR_P3_OUTPUT_MODE)) begin
            p3_output_mode_q <= sfr_req.wdata;
         end
         if (wr_hit(sfr_req, ADDR_P3_SKIP)) begin
            p3_skip_q <= sfr_req.wdata;
         end
      end
   end

   // Data latches and the port-4 output mode. Bit 7 of port 4 is masked so it can never hold a one.
   // port-4 latch
   always_ff @(posedge mclk) begin
      if (srst) begin
         p3_data_q        <= RST_P3_DATA;
         p4_data_q        <= RST_P4_DATA;
         p4_output_mode_q <= RST_P4_OUTPUT_MODE;
      end else begin
         if (wr_hit(sfr_req, ADDR_P3_DATA)) begin
            p3_data_q <= sfr_req.wdata;
         end
         if (wr_hit(sfr_req, ADDR_P4_DATA)) begin
            p4_data_q <= sfr_req.wdata & P4_MASK;
         end
         if (wr_hit(sfr_req, ADDR_P4_OUTPUT_MODE)) begin
            p4_output_mode_q <= sfr_req.wdata & P4_MASK;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Pin input synchronisers and read-back.
   ////////////////////////////////////////////////////////////////////////

   // Pads are asynchronous; two flops before anything looks at them.
   always_ff @(posedge mclk) begin
      if (srst) begin
         p3_meta_q <= 8'h00;
         p3_sync_q <= 8'h00;
         p4_meta_q <= 8'h00;
         p4_sync_q <= 8'h00;
      end else begin
         p3_meta_q <= p3_pin_in;
         p3_sync_q <= p3_meta_q;
         p4_meta_q <= p4_pin_in;
         p4_sync_q <= p4_meta_q;
      end
   end

   // Read data is registered and valid the cycle after the read strobe;
   // unmapped addresses answer zero.
   // read mux
   always_ff @(posedge mclk) begin
      if (srst) begin
         rdata_q <= READ_NONE;
      end else if (sfr_req.rd) begin
         case (sfr_req.addr)
            ADDR_P3_ANALOG_SEL:  rdata_q <= p3_analog_sel_q;
            ADDR_P3_OUTPUT_MODE: rdata_q <= p3_output_mode_q;
            ADDR_P3_SKIP:        rdata_q <= p3_skip_q;
            ADDR_P3_DATA:        rdata_q <= p3_sync_q & p3_analog_sel_q;
            ADDR_P4_DATA:        rdata_q <= p4_sync_q & P4_MASK;
            ADDR_P4_OUTPUT_MODE: rdata_q <= p4_output_mode_q & P4_MASK;
            default:             rdata_q <= READ_NONE;
         endcase
      end
   end

   assign sfr_rdata = rdata_q;
   assign p3_skip   = p3_skip_q;

   ////////////////////////////////////////////////////////////////////////
   // Pad drive.
   ////////////////////////////////////////////////////////////////////////

   // A peripheral routed by the crossbar overrides the latch per pin.
   assign p3_val = (p3_xbar.sel & p3_xbar.val) | (~p3_xbar.sel & p3_data_q);
   assign p4_val = ((p4_xbar.sel & p4_xbar.val) | (~p4_xbar.sel & p4_data_q))
                   & P4_MASK;

   // Analog pins lose output mode, pullup, driver and receiver together.
   // analog isolation
   assign p3_pp_eff        = p3_output_mode_q & p3_analog_sel_q;
   assign p3_pad.out       = p3_val & p3_analog_sel_q;
   assign p3_pad.oe_n      = drive_n(p3_val, p3_pp_eff, p3_analog_sel_q);
   assign p3_pad.pullup_en = p3_analog_sel_q;
   assign p3_pad.rx_en     = p3_analog_sel_q;

   // Port 4 is digital only; the unused bit is never driven.
   // port-4 drive
   assign p4_pad.out       = p4_val;
   assign p4_pad.oe_n      = drive_n(p4_val, p4_output_mode_q, P4_MASK);
   assign p4_pad.pullup_en = P4_MASK;
   assign p4_pad.rx_en     = P4_MASK;

   ////////////////////////////////////////////////////////////////////////
   // Assertions.
   ////////////////////////////////////////////////////////////////////////

   AST_P3_ANALOG_OFF: assert property (
      @(posedge mclk) disable iff (srst)
      ((p3_pad.pullup_en | p3_pad.rx_en | ~p3_pad.oe_n)
       & ~p3_analog_sel_q) == 8'h00)
      else $error("Analog port-3 pin has a digital function enabled.");

   // Checked on the edge after a reset edge, so the unknown power-up
   // contents before the first reset edge are never compared.
   AST_P3_SEL_RESET: assert property (
      @(posedge mclk) srst |=> p3_analog_sel_q == RST_P3_ANALOG_SEL
                        && p3_output_mode_q == RST_P3_OUTPUT_MODE)
      else $error("Port-3 mode registers wrong after reset.");

   AST_P3_OPEN_DRAIN: assert property (
      @(posedge mclk) disable iff (srst)
      (~p3_pad.oe_n & ~p3_output_mode_q & p3_val) == 8'h00)
      else $error("Open-drain port-3 pin drives a high.");

   AST_P3_ANALOG_NODRIVE: assert property (
      @(posedge mclk) disable iff (srst)
      (~p3_pad.oe_n & ~p3_analog_sel_q) == 8'h00)
      else $error("Analog port-3 pin is driven.");

   AST_P3_SKIP_WRITE: assert property (
      @(posedge mclk) disable iff (srst)
      wr_hit(sfr_req, ADDR_P3_SKIP) |=> p3_skip == $past(sfr_req.wdata))
      else $error("Skip output does not follow its write.");

   AST_P4_TOP_ZERO: assert property (
      @(posedge mclk) disable iff (srst)
      sfr_req.rd && (sfr_req.addr == ADDR_P4_DATA ||
                     sfr_req.addr == ADDR_P4_OUTPUT_MODE)
      |=> sfr_rdata[P4_PINS] == 1'b0)
      else $error("Unused port-4 bit reads one.");

   AST_P4_DRIVE: assert property (
      @(posedge mclk) disable iff (srst)
      (p4_pad.oe_n[P4_PINS-1:0] ==
       ~(p4_output_mode_q[P4_PINS-1:0] | ~p4_val[P4_PINS-1:0]))
      && p4_pad.oe_n[P4_PINS])
      else $error("Port-4 pin drive does not match mode and value.");

   AST_P4_READ_PIN: assert property (
      @(posedge mclk) disable iff (srst)
      sfr_req.rd && sfr_req.addr == ADDR_P4_DATA
      |=> sfr_rdata[P4_PINS-1:0] == $past(p4_sync_q[P4_PINS-1:0]))
      else $error("Port-4 read does not show the pin levels.");

   AST_P4_RESET: assert property (
      @(posedge mclk) srst |=> p4_data_q == RST_P4_DATA)
      else $error("Port-4 latch wrong after reset.");

   AST_P3_READ: assert property (
      @(posedge mclk) disable iff (srst)
      sfr_req.rd && sfr_req.addr == ADDR_P3_DATA
      |=> sfr_rdata == ($past(p3_sync_q) & $past(p3_analog_sel_q)))
      else $error("Port-3 read does not mask analog pins.");

   AST_P4_DIGITAL: assert property (
      @(posedge mclk) disable iff (srst)
      p4_pad.rx_en[P4_PINS-1:0] == P4_MASK[P4_PINS-1:0])
      else $error("Port-4 receiver disabled.");

endmodule : port34_pins

// ### port34_pkg.sv
package port34_pkg;

   // Register addresses on the special-function register bus.
   localparam logic [7:0] ADDR_P4_OUTPUT_MODE = 8'hae;
   localparam logic [7:0] ADDR_P3_OUTPUT_MODE = 8'haf;
   localparam logic [7:0] ADDR_P3_DATA        = 8'hb0;
   localparam logic [7:0] ADDR_P4_DATA        = 8'hb5;
   localparam logic [7:0] ADDR_P3_SKIP        = 8'hd7;
   localparam logic [7:0] ADDR_P3_ANALOG_SEL  = 8'hf4;

   // Reset values.
   localparam logic [7:0] RST_P4_OUTPUT_MODE = 8'h00;
   localparam logic [7:0] RST_P3_OUTPUT_MODE = 8'h00;
   localparam logic [7:0] RST_P3_DATA        = 8'hff;
   localparam logic [7:0] RST_P4_DATA        = 8'h7f;
   localparam logic [7:0] RST_P3_SKIP        = 8'h00;
   localparam logic [7:0] RST_P3_ANALOG_SEL  = 8'hff;

   // Port 4 has seven pins; bit 7 of its registers is unimplemented.
   localparam int         P4_PINS   = 7;
   localparam logic [7:0] P4_MASK   = 8'h7f;
   localparam logic [7:0] READ_NONE = 8'h00;

   // Register-bus request from the core.
   typedef struct packed {
      logic [7:0] addr;
      logic       wr;
      logic       rd;
      logic [7:0] wdata;
   } sfr_req_t;

   // Crossbar override for one port: per-pin take-over and value.
   typedef struct packed {
      logic [7:0] sel;
      logic [7:0] val;
   } xbar_t;

   // Pad controls for one eight-pin port.
   typedef struct packed {
      logic [7:0] out;
      logic [7:0] oe_n;
      logic [7:0] pullup_en;
      logic [7:0] rx_en;
   } pad_t;

endpackage : port34_pkg

// ### pin_partner.sv
`timescale 1ns/1ps
// Outside world of both ports: pin resolution and the crossbar decoder.
module pin_partner (
   // Clock
   input  wire logic              mclk,
   // Pads and skip from the block
   input  wire port34_pkg::pad_t  p3_pad,
   input  wire port34_pkg::pad_t  p4_pad,
   input  wire logic [7:0]        p3_skip,
   // Outside drivers set by the bench, port 4 in the top byte
   input  wire logic [15:0]       ext_en,
   input  wire logic [15:0]       ext_val,
   // Crossbar requests set by the bench
   input  wire logic [7:0]        xsel,
   input  wire logic [7:0]        xval,
   // Levels and crossbar values back to the block
   output logic [7:0]             p3_pin_in,
   output logic [7:0]             p4_pin_in,
   output port34_pkg::xbar_t      p3_xbar,
   output port34_pkg::xbar_t      p4_xbar
);
   import port34_pkg::*;

   logic [15:0] pin_q = 16'h0000;

   // A floating pin with no pull shows a changing level, so a stale value
   // can never pass for a real reading.
   function automatic logic [7:0] level(pad_t p, logic [7:0] en,
                                        logic [7:0] val, logic [7:0] last);
      logic [7:0] r;
      for (int i = 0; i < 8; i++) begin
         r[i] = !p.oe_n[i] ? p.out[i] : en[i] ? val[i] :
                p.pullup_en[i] ? 1'b1 : ~last[i];
      end
      return r;
   endfunction : level

   ////////////////////////////////////////////////////////////////////////
   // Pin levels follow the pad driver first, then outside parts, then pull.
   always_ff @(posedge mclk) pin_q <= {p4_pin_in, p3_pin_in};
   assign p3_pin_in = level(p3_pad, ext_en[7:0], ext_val[7:0], pin_q[7:0]);
   assign p4_pin_in = level(p4_pad, ext_en[15:8], ext_val[15:8], pin_q[15:8]);

   ////////////////////////////////////////////////////////////////////////
   // skip passes over
   // The decoder never claims a pin that port 3 marks as skipped.
   assign p3_xbar = '{sel: xsel & ~p3_skip, val: xval};
   assign p4_xbar = '{sel: xsel & 8'h7f, val: xval};
endmodule : pin_partner

// ### tb_port34_pins.sv
`timescale 1ns/1ps
module tb_port34_pins;
   import port34_pkg::*;
   typedef struct {string name; logic [7:0] exp;} exp_t;
   logic        mclk = 0, srst = 1, rd_seen = 0;
   sfr_req_t    sfr_req = '0;
   logic [7:0]  sfr_rdata, p3_skip, p3_pin_in, p4_pin_in, a, v;
   logic [7:0]  xsel = 8'h00, xval = 8'h00;
   logic [15:0] ext_en = 16'h0000, ext_val = 16'h0000;
   xbar_t       p3_xbar, p4_xbar;
   pad_t        p3_pad, p4_pad;
   exp_t        exp_q[$], e;
   int          mismatches = 0, check_count = 0;

   port34_pins i_port34_pins (.mclk(mclk), .srst(srst), .sfr_req(sfr_req),
      .sfr_rdata(sfr_rdata), .p3_xbar(p3_xbar), .p4_xbar(p4_xbar),
      .p3_skip(p3_skip), .p3_pin_in(p3_pin_in), .p3_pad(p3_pad),
      .p4_pin_in(p4_pin_in), .p4_pad(p4_pad));
   pin_partner i_pin_partner (.mclk(mclk), .p3_pad(p3_pad), .p4_pad(p4_pad),
      .p3_skip(p3_skip), .ext_en(ext_en), .ext_val(ext_val), .xsel(xsel),
      .xval(xval), .p3_pin_in(p3_pin_in), .p4_pin_in(p4_pin_in),
      .p3_xbar(p3_xbar), .p4_xbar(p4_xbar));

   ////////////////////////////////////////////////////////////////////////
   // Clock, and a watchdog far beyond the roughly 60 cycles of the tests.
   initial forever #20 mclk = ~mclk;
   initial begin
      repeat (3000) @(posedge mclk);
      mismatches++;
      test_done();
   end

   task automatic check(string name, logic [7:0] seen, logic [7:0] exp);
      check_count++;
      if (seen !== exp) begin
         mismatches++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   // One register access; the strobe is dropped a cycle later so that
   // back-to-back calls never assign it twice in one time step.
   task automatic acc(logic wr, logic [7:0] addr, logic [7:0] wd,
                      logic [7:0] exp, string name);
      @(posedge mclk);
      sfr_req <= '{addr: addr, wr: wr, rd: !wr, wdata: wd};
      if (!wr) exp_q.push_back('{name, exp});
      @(posedge mclk);
      sfr_req.wr <= 1'b0;
      sfr_req.rd <= 1'b0;
   endtask : acc

   task automatic test_done();
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : test_done

   ////////////////////////////////////////////////////////////////////////
   // Read data lands one cycle after the strobe; compare it to the oldest note.
   always @(posedge mclk) rd_seen <= sfr_req.rd && !srst;
   always @(negedge mclk) begin
      if (rd_seen) begin
         e = exp_q.pop_front();
         check(e.name, sfr_rdata, e.exp);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Main sequence.
   initial begin
      void'($urandom(2199));
      repeat (2) @(posedge mclk);
      srst <= 1'b0;
      acc(0, ADDR_P4_OUTPUT_MODE, 8'h00, 8'h00, "p4 mode");
      acc(0, ADDR_P3_OUTPUT_MODE, 8'h00, 8'h00, "p3 mode");
      acc(0, ADDR_P4_DATA, 8'h00, 8'h7f, "p4 data");
      acc(0, ADDR_P3_SKIP, 8'h00, 8'h00, "p3 skip");
      acc(0, ADDR_P3_ANALOG_SEL, 8'h00, 8'hff, "analog sel");
      acc(0, 8'h00, 8'h00, READ_NONE, "unmapped");
      $display("test reset values done");
      // Port 4: push-pull drive, open-drain release against outside drivers, then crossbar drive.
      v = 8'($urandom);
      acc(1, ADDR_P4_OUTPUT_MODE, 8'hff, 8'h00, "");
      acc(0, ADDR_P4_OUTPUT_MODE, 8'h00, 8'h7f, "p4 mode");
      acc(1, ADDR_P4_DATA, v, 8'h00, "");
      repeat (3) @(posedge mclk);
      acc(0, ADDR_P4_DATA, 8'h00, v & P4_MASK, "p4 pins");
      check("p4 oe_n", p4_pad.oe_n & P4_MASK, 8'h00);
      check("p4 out", p4_pad.out, v & P4_MASK);
      check("p4 pullup", p4_pad.pullup_en, P4_MASK);
      check("p4 rx_en", p4_pad.rx_en & P4_MASK, 8'h7f);
      acc(1, ADDR_P4_OUTPUT_MODE, 8'h00, 8'h00, "");
      acc(1, ADDR_P4_DATA, 8'hff, 8'h00, "");
      ext_en <= 16'hff00;
      ext_val <= {~v, 8'h00};
      repeat (3) @(posedge mclk);
      acc(0, ADDR_P4_DATA, 8'h00, ~v & P4_MASK, "p4 live");
      ext_en <= 16'h0000;
      acc(1, ADDR_P4_OUTPUT_MODE, 8'hff, 8'h00, "");
      xsel <= 8'hff;
      xval <= ~v;
      repeat (3) @(posedge mclk);
      acc(0, ADDR_P4_DATA, 8'h00, ~v & P4_MASK, "p4 crossbar");
      $display("test port 4 done");
      // Port 3: random analog pins, held high outside, skipped by software.
      xsel <= 8'h00;
      a = 8'($urandom);
      acc(1, ADDR_P3_ANALOG_SEL, a, 8'h00, "");
      acc(1, ADDR_P3_SKIP, ~a, 8'h00, "");
      acc(1, ADDR_P3_OUTPUT_MODE, 8'hff, 8'h00, "");
      ext_en <= 16'h00ff;
      ext_val <= 16'h00ff;
      repeat (3) @(posedge mclk);
      check("p3 oe_n", p3_pad.oe_n, ~a);
      check("p3 pullup", p3_pad.pullup_en, a);
      check("p3 rx_en", p3_pad.rx_en, a);
      check("p3 out", p3_pad.out, a);
      check("p3 skip out", p3_skip, ~a);
      acc(0, ADDR_P3_DATA, 8'h00, a, "p3 pins");
      acc(0, ADDR_P3_SKIP, 8'h00, ~a, "p3 skip");
      $display("test port 3 done");
      // A second reset restores the port-3 analog select and output mode registers.
      srst <= 1'b1;
      repeat (2) @(posedge mclk);
      srst <= 1'b0;
      acc(0, ADDR_P3_ANALOG_SEL, 8'h00, 8'hff, "analog sel");
      acc(0, ADDR_P3_OUTPUT_MODE, 8'h00, 8'h00, "p3 mode");
      repeat (2) @(posedge mclk);
      $display("test second reset done");
      test_done();
   end
endmodule : tb_port34_pins
